/* File: aotpg_regs.svh */
// register offsets, field positions, reset values, pattern words and timing
// counts of the output test-pattern generator; definitions only
`ifndef AOTPG_REGS_SVH
`define AOTPG_REGS_SVH
// ==========================================
// register byte offsets (apb, one word each)
`define AOTPG_ADDR_CTRL 8'h00
`define AOTPG_ADDR_FMT 8'h04
`define AOTPG_ADDR_USER1 8'h08
`define AOTPG_ADDR_USER2 8'h0c
`define AOTPG_ADDR_STAT 8'h10
// ==========================================
// field positions
`define AOTPG_CTRL_LONG_RST 4
`define AOTPG_CTRL_SHORT_RST 5
`define AOTPG_FMT_OFFBIN 0
`define AOTPG_FMT_ONE_LANE 1
`define AOTPG_FMT_LEN_LO 8
// ==========================================
// reset values and limits
`define AOTPG_LEN_RST 5'h10
`define AOTPG_LEN_MIN 5'h0c
`define AOTPG_LEN_MAX 5'h10
`define AOTPG_USER_RST 16'h0000
`define AOTPG_WORD_BITS 16
`define AOTPG_PRBS_BITS 14
// cycles after reset release before the straps are caught
`define AOTPG_STRAP_WAIT 2'h3
// ==========================================
// pattern words, 16-bit msb-aligned form
`define AOTPG_W_MID 16'h8000
`define AOTPG_W_POS_FS 16'hfffc
`define AOTPG_W_NEG_FS 16'h0000
`define AOTPG_W_CHECK_A 16'haaa8
`define AOTPG_W_CHECK_B 16'h5554
`define AOTPG_W_ONES 16'hfffc
`define AOTPG_W_ZEROS 16'h0000
`define AOTPG_W_SYNC16 16'h01fc
`define AOTPG_W_SYNC12 16'h03f0
`define AOTPG_W_ONE_HIGH 16'h8000
`define AOTPG_W_MIXED16 16'ha19c
`define AOTPG_W_MIXED12 16'ha330
`endif

/* File: aotpg_pkg.sv */
// types shared by the test-pattern generator modules
// assumes nothing beyond a systemverilog compiler
package aotpg_pkg;
   // ==========================================
   // pattern select codes
   typedef enum logic [3:0] {
      pat_off = 4'h0,
      pat_mid = 4'h1,
      pat_pos_fs = 4'h2,
      pat_neg_fs = 4'h3,
      pat_checker = 4'h4,
      pat_long_prbs = 4'h5,
      pat_short_prbs = 4'h6,
      pat_one_zero = 4'h7,
      pat_user = 4'h8,
      pat_bit_toggle = 4'h9,
      pat_sync = 4'ha,
      pat_one_high = 4'hb,
      pat_mixed = 4'hc
   } aotpg_code_type;
   typedef logic [15:0] aotpg_word_type;
endpackage

/* File: aotpg_sync.sv */
// two flip-flop synchroniser for a group of unrelated levels
// assumes each bit is a slow level; no bus coherence is given
module aotpg_sync #(
   parameter int WIDTH = 1
) (
   // clock, reset, enable
   input logic clk,
   input logic rst_n,
   input logic ce,
   // levels
   input logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] q_q;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q_q <= '0;
      end else if (ce) begin
         meta_q <= d;
         q_q <= meta_q;
      end
   end
   assign q = q_q;
endmodule

/* File: aotpg_prbs.sv */
// pseudorandom word source: 14 serial bits per step, msb first
// assumes seed and step are one-cycle pulses on the same clock
module aotpg_prbs #(
   parameter int ORDER = 9,
   parameter int TAP = 4,
   parameter bit INVERT = 1'b0,
   parameter int BITS = 14
) (
   // clock, reset, enable
   input logic clk,
   input logic rst_n,
   input logic ce,
   // control
   input logic seed,
   input logic step,
   // current word
   output logic [BITS-1:0] word
);
   // advance the reference register by BITS bits and collect the output
   function automatic logic [ORDER+BITS-1:0] adv(input logic [ORDER-1:0] w);
      logic [ORDER-1:0] r;
      logic [BITS-1:0] o;
      logic nb;
      r = w;
      o = '0;
      nb = 1'b0;
      for (int i = 0; i < BITS; i++) begin
         o = {o[BITS-2:0], r[ORDER-1] ^ INVERT};
         // inverted variant runs xnor feedback so its register holds the complement, which the output inversion undoes
         nb = r[ORDER-1] ^ r[ORDER-1-TAP] ^ INVERT;
         r = {r[ORDER-2:0], nb};
      end
      return {o, r};
   endfunction

   // emitted stream starts all ones whichever variant this is
   localparam logic [ORDER+BITS-1:0] FIRST = adv({ORDER{~INVERT}});

   logic [ORDER-1:0] win_q;
   logic [BITS-1:0] word_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {word_q, win_q} <= FIRST;
      end else if (ce) begin
         if (seed) begin
            {word_q, win_q} <= FIRST;
         end else if (step) begin
            {word_q, win_q} <= adv(win_q);
         end
      end
   end
   assign word = word_q;
endmodule

/* File: aotpg_top.sv */
// output test-pattern generator with strap handling and lane serialisers
// assumes apb master on pclk; straps, selects and sample clock are async pins;
// converter samples arrive on pclk in offset binary
`include "aotpg_regs.svh"

module aotpg_top
   import aotpg_pkg::*;
#(
   parameter int CHANNELS = 4,
   parameter int SAMPLE_BITS = 14
) (
   // clock, reset, enable
   input logic pclk,
   input logic presetn,
   input logic ce,
   // apb slave
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // straps and bank selects
   input logic lane_strap_pin,
   input logic pattern_strap_pin,
   input logic bank1_select_n,
   input logic bank2_select_n,
   // sample clock and converter data
   input logic sample_clk,
   input logic [2*CHANNELS*SAMPLE_BITS-1:0] adc_data,
   // link outputs
   output logic frame_clock_out_a,
   output logic frame_clock_out_b,
   output logic data_clock_out_a,
   output logic data_clock_out_b,
   output logic [2*CHANNELS-1:0] bank1_data_lanes,
   output logic [2*CHANNELS-1:0] bank2_data_lanes
);
   // ==========================================
   // pin synchronisers and frame edge
   logic [4:0] pin_s;
   logic smp_d_q;
   logic frame_q;
   logic dclk_q;
   logic half_q;
   logic frame_rise;
   logic [1:0] sel_s;

   aotpg_sync #(.WIDTH(5)) u_pins (
      .clk(pclk),
      .rst_n(presetn),
      .ce(ce),
      .d({sample_clk, bank2_select_n, bank1_select_n, pattern_strap_pin, lane_strap_pin}),
      .q(pin_s)
   );
   assign sel_s = pin_s[3:2];
   assign frame_rise = pin_s[4] & ~smp_d_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smp_d_q <= 1'b0;
         frame_q <= 1'b0;
         dclk_q <= 1'b0;
         half_q <= 1'b0;
      end else if (ce) begin
         smp_d_q <= pin_s[4];
         frame_q <= smp_d_q;             // delayed to line up with lane bits
         dclk_q <= frame_rise ? 1'b0 : ~dclk_q;
         half_q <= frame_rise ? ~half_q : half_q;
      end
   end
   assign frame_clock_out_a = frame_q;
   assign frame_clock_out_b = frame_q;
   assign data_clock_out_a = dclk_q;
   assign data_clock_out_b = dclk_q;

   // ==========================================
   // power-up strap capture
   logic [1:0] wait_q;
   logic strap_done_q;
   logic strapped_test_pattern_q;
   logic strap_one_lane_q;

   // sampled once, after the synchronisers have filled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q <= 2'h0;
         strap_done_q <= 1'b0;
         strapped_test_pattern_q <= 1'b0;
         strap_one_lane_q <= 1'b0;
      end else if (ce && !strap_done_q) begin
         if (wait_q == `AOTPG_STRAP_WAIT) begin
            strap_done_q <= 1'b1;
            strapped_test_pattern_q <= pin_s[1] & (&sel_s);
            strap_one_lane_q <= ~pin_s[0] & (&sel_s);
         end else begin
            wait_q <= wait_q + 2'h1;
         end
      end
   end

   // ==========================================
   // apb register file
   aotpg_code_type code_q [2];
   logic offbin_q;
   logic fmt_one_lane_q;
   logic [4:0] len_q;
   logic [15:0] user1_q;
   logic [15:0] user2_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic lane_mode_select;
   logic wr;
   logic [1:0] cfg_ok;
   logic [1:0] ctrl_wr;
   logic [4:0] new_len;

   // strap wins while both selects stay high
   assign lane_mode_select = (&sel_s && strap_done_q) ? strap_one_lane_q : fmt_one_lane_q;
   assign wr = psel & penable & pready_q & pwrite;
   assign cfg_ok = ~sel_s;
   assign ctrl_wr = {2{wr && paddr == `AOTPG_ADDR_CTRL}} & cfg_ok;
   assign new_len = pwdata[`AOTPG_FMT_LEN_LO +: 5];

   function automatic logic mapped(input logic [7:0] a);
      return a == `AOTPG_ADDR_CTRL || a == `AOTPG_ADDR_FMT || a == `AOTPG_ADDR_USER1
         || a == `AOTPG_ADDR_USER2 || a == `AOTPG_ADDR_STAT;
   endfunction

   function automatic logic [31:0] rd_word(input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0;
      unique case (a)
         `AOTPG_ADDR_CTRL: r = {28'h0, code_q[0]};
         `AOTPG_ADDR_FMT: r = {19'h0, len_q, 6'h0, fmt_one_lane_q, offbin_q};
         `AOTPG_ADDR_USER1: r = {16'h0, user1_q};
         `AOTPG_ADDR_USER2: r = {16'h0, user2_q};
         `AOTPG_ADDR_STAT: r = {20'h0, code_q[1], code_q[0], sel_s,
            strapped_test_pattern_q, lane_mode_select};
         default: r = 32'h0;
      endcase
      return r;
   endfunction

   // answer prepared in setup, shown in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else if (ce) begin
         pready_q <= psel & ~penable;
         if (psel && !penable) begin
            pslverr_q <= ~mapped(paddr);
            prdata_q <= pwrite ? 32'h0 : rd_word(paddr);
         end
      end
   end
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;

   // shared format and user words take a write if either bank is selected
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         offbin_q <= 1'b0;
         fmt_one_lane_q <= 1'b0;
         len_q <= `AOTPG_LEN_RST;
         user1_q <= `AOTPG_USER_RST;
         user2_q <= `AOTPG_USER_RST;
      end else if (ce && wr && |cfg_ok) begin
         if (paddr == `AOTPG_ADDR_FMT) begin
            offbin_q <= pwdata[`AOTPG_FMT_OFFBIN];
            fmt_one_lane_q <= pwdata[`AOTPG_FMT_ONE_LANE];
            // lengths outside 12..16 leave the old length in place
            if (new_len >= `AOTPG_LEN_MIN && new_len <= `AOTPG_LEN_MAX) begin
               len_q <= new_len;
            end
         end
         if (paddr == `AOTPG_ADDR_USER1) begin
            user1_q <= pwdata[15:0];
         end
         if (paddr == `AOTPG_ADDR_USER2) begin
            user2_q <= pwdata[15:0];
         end
      end
   end

   // ==========================================
   // pattern word selection
   function automatic aotpg_word_type pattern_word(input aotpg_code_type code,
      input logic alt, input logic [4:0] len, input logic offbin,
      input logic [13:0] longw, input logic [13:0] shortw, input aotpg_word_type normal);
      aotpg_word_type w;
      logic fmt;
      logic full;
      logic is12;
      w = normal;
      fmt = 1'b0;
      full = 1'b0;
      is12 = (len == `AOTPG_LEN_MIN);
      unique case (code)
         pat_mid: begin
            w = `AOTPG_W_MID;
            fmt = 1'b1;
         end
         pat_pos_fs: begin
            w = `AOTPG_W_POS_FS;
            fmt = 1'b1;
         end
         pat_neg_fs: begin
            w = `AOTPG_W_NEG_FS;
            fmt = 1'b1;
         end
         pat_checker: w = alt ? `AOTPG_W_CHECK_B : `AOTPG_W_CHECK_A;
         pat_long_prbs: begin
            w = {longw, 2'b00};
            fmt = 1'b1;
            full = 1'b1;
         end
         pat_short_prbs: begin
            w = {shortw, 2'b00};
            fmt = 1'b1;
            full = 1'b1;
         end
         pat_one_zero: w = alt ? `AOTPG_W_ZEROS : `AOTPG_W_ONES;
         pat_user: w = alt ? user2_q : user1_q;
         pat_bit_toggle: w = `AOTPG_W_CHECK_A;
         pat_sync: w = is12 ? `AOTPG_W_SYNC12 : `AOTPG_W_SYNC16;
         pat_one_high: w = `AOTPG_W_ONE_HIGH;
         pat_mixed: w = is12 ? `AOTPG_W_MIXED12 : `AOTPG_W_MIXED16;
         // off and spare codes pass samples
         default: begin
            w = normal;
            fmt = 1'b1;
         end
      endcase
      // twos complement unless offset binary chosen
      if (fmt && !offbin) begin
         w[15] = ~w[15];
      end
      if (!full) begin
         w = w & ~(16'hffff >> len);
      end
      return w;
   endfunction

   // ==========================================
   // per-bank generators and serialisers
   logic [2*CHANNELS-1:0] lanes [2];
   logic load;

   // one lane carries 16 bits over two frames, so load every other frame
   assign load = frame_rise & (~lane_mode_select | half_q);

   for (genvar b = 0; b < 2; b++) begin : g_bank
      aotpg_code_type cur;
      logic alt_q;
      logic two_word;
      logic [13:0] longw;
      logic [13:0] shortw;

      assign cur = strapped_test_pattern_q ? pat_one_high : code_q[b];
      assign two_word = cur == pat_checker || cur == pat_one_zero || cur == pat_user;

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            code_q[b] <= pat_off;
            alt_q <= 1'b0;
         end else if (ce) begin
            if (ctrl_wr[b]) begin
               code_q[b] <= aotpg_code_type'(pwdata[3:0]);
               alt_q <= 1'b0;
            end else if (load && two_word) begin
               alt_q <= ~alt_q;
            end
         end
      end

      aotpg_prbs #(.ORDER(23), .TAP(5), .INVERT(1'b1), .BITS(`AOTPG_PRBS_BITS)) u_long (
         .clk(pclk),
         .rst_n(presetn),
         .ce(ce),
         .seed(ctrl_wr[b] & pwdata[`AOTPG_CTRL_LONG_RST]),
         .step(load && cur == pat_long_prbs),
         .word(longw)
      );

      aotpg_prbs #(.ORDER(9), .TAP(4), .INVERT(1'b0), .BITS(`AOTPG_PRBS_BITS)) u_short (
         .clk(pclk),
         .rst_n(presetn),
         .ce(ce),
         .seed(ctrl_wr[b] & pwdata[`AOTPG_CTRL_SHORT_RST]),
         .step(load && cur == pat_short_prbs),
         .word(shortw)
      );

      for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
         aotpg_word_type sh_q;
         aotpg_word_type word;
         logic lane1_q;
         logic lane0_q;

         assign word = pattern_word(cur, alt_q, len_q, offbin_q, longw, shortw,
            {adc_data[(b*CHANNELS+c)*SAMPLE_BITS +: SAMPLE_BITS],
             {(`AOTPG_WORD_BITS-SAMPLE_BITS){1'b0}}});

         // two lanes split the word in halves in two-lane mode, msb first; one-lane mode sends all 16 bits on lane0
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sh_q <= '0;
               lane1_q <= 1'b0;
               lane0_q <= 1'b0;
            end else if (ce) begin
               if (load) begin
                  sh_q <= word;
               end else if (lane_mode_select) begin
                  sh_q <= {sh_q[14:0], 1'b0};
               end else begin
                  sh_q <= {sh_q[14:8], 1'b0, sh_q[6:0], 1'b0};
               end
               lane1_q <= lane_mode_select ? 1'b0 : sh_q[15];
               lane0_q <= lane_mode_select ? sh_q[15] : sh_q[7];
            end
         end
         assign lanes[b][2*c+1] = lane1_q;
         assign lanes[b][2*c] = lane0_q;
      end
   end

   assign bank1_data_lanes = lanes[0];
   assign bank2_data_lanes = lanes[1];
endmodule

/* File: aotpg_rx_model.sv */
// receiver model: rebuilds 16-bit words of one channel from a two-lane link
// assumes frame clock and lanes come straight from the generator, two-lane mode
module aotpg_rx_model (
   // clock and reset
   input logic pclk,
   input logic presetn,
   // link side
   input logic frame_clk,
   input logic [1:0] lanes,
   // rebuilt word, valid for one cycle
   output logic [15:0] word,
   output logic valid
);
   logic frame_q;
   logic [2:0] cnt_q;
   logic [6:0] hi_q;
   logic [6:0] lo_q;
   // ==========================================
   // capture: the frame rise carries the first bit, so no bit is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_q <= 1'b0;
         cnt_q <= 3'h0;
         hi_q <= 7'h00;
         lo_q <= 7'h00;
         word <= 16'h0000;
         valid <= 1'b0;
      end else begin
         frame_q <= frame_clk;
         valid <= 1'b0;
         hi_q <= {hi_q[5:0], lanes[1]};
         lo_q <= {lo_q[5:0], lanes[0]};
         if (frame_clk && !frame_q) begin
            cnt_q <= 3'h1;
         end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q + 3'h1;
            // eighth bit closes the word: lane1 is the upper half
            if (cnt_q == 3'h7) begin
               word <= {hi_q, lanes[1], lo_q, lanes[0]};
               valid <= 1'b1;
            end
         end
      end
   end
endmodule

/* File: aotpg_top_asserts.sv */
// checker for the generator top: apb answer timing and link clocks
// assumes it is bound to aotpg_top; all checks live in the pclk domain
module aotpg_top_asserts #(
   parameter int CHANNELS = 4,
   parameter int SAMPLE_BITS = 14
) (
   // clock, reset, enable
   input logic pclk,
   input logic presetn,
   input logic ce,
   // apb
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   // link
   input logic sample_clk,
   input logic frame_clock_out_a,
   input logic frame_clock_out_b,
   input logic data_clock_out_a,
   input logic data_clock_out_b
);
   logic setup;
   logic bad_addr;
   // setup phase and unmapped or misaligned address
   assign setup = psel && !penable;
   assign bad_addr = (paddr > 8'h10) || (paddr[1:0] != 2'b00);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================
   // apb answer
   a_ready_after_setup:
      assert property (setup && ce |=> pready) else $error("no ready after setup");
   a_ready_single:
      assert property (pready |=> !pready) else $error("ready longer than one cycle");
   a_idle_no_ready:
      assert property (!setup |=> !pready) else $error("ready without setup");
   a_unmapped_err:
      assert property (setup && ce && bad_addr |=> pready && pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_mapped_no_err:
      assert property (setup && !bad_addr |=> !pslverr) else $error("error on mapped access");
   a_write_zero_data:
      assert property (setup && ce && pwrite |=> prdata == 32'h0) else $error("data on write");
   // ==========================================
   // link clocks keep running, same on both banks
   a_frame_follows:
      assert property ($rose(sample_clk) && ce && presetn |-> ##[2:4] $rose(frame_clock_out_a))
      else $error("frame clock does not follow sample clock");
   a_banks_clock_same:
      assert property (frame_clock_out_a == frame_clock_out_b
         && data_clock_out_a == data_clock_out_b) else $error("bank clocks differ");
   a_dclk_after_frame:
      // data clock is forced low on every frame edge, so it rises in the same cycle as the frame clock
      assert property ($rose(frame_clock_out_a) |-> data_clock_out_a ##1 !data_clock_out_a
         ##1 data_clock_out_a) else $error("data clock not aligned to frame");
   c_write: cover property (setup && pwrite ##1 pready);
   c_error: cover property (pready && pslverr);
   c_frame: cover property ($rose(frame_clock_out_a));
endmodule

bind aotpg_top aotpg_top_asserts #(.CHANNELS(CHANNELS), .SAMPLE_BITS(SAMPLE_BITS)) u_asserts (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sample_clk(sample_clk), .frame_clock_out_a(frame_clock_out_a),
   .frame_clock_out_b(frame_clock_out_b), .data_clock_out_a(data_clock_out_a),
   .data_clock_out_b(data_clock_out_b)
);

/* File: testbench.sv */
// self-checking bench: apb register calls, words rebuilt by the receiver model
// assumes aotpg_top, aotpg_rx_model and the register header
`include "aotpg_regs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, rerr, rx_valid, rx2_valid;
   logic lane_strap_pin = 1'b1;
   logic pattern_strap_pin = 1'b1;
   logic bank1_select_n = 1'b1;
   logic bank2_select_n = 1'b1;
   logic sample_clk = 1'b0;
   logic [111:0] adc_data = {8{14'h1234}};
   logic fca, fcb, dca, dcb;
   logic [7:0] lanes1, lanes2;
   logic [15:0] rx_word, rx2_word, w;
   int fail_count = 0;
   int checks = 0;
   // {fmt, code, expected word}; 0x1234 offset binary reads 0xc8d0 in twos complement
   logic [35:0] tab [0:15] = '{36'h100010000, 36'h100027ffc, 36'h100038000, 36'h10009aaa8,
      36'h1000a01fc, 36'h1000b8000, 36'h1000ca19c, 36'h1000dc8d0, 36'h1000fc8d0,
      36'h10000c8d0, 36'h100118000, 36'h10012fffc, 36'h1001048d0, 36'h0c00a03f0,
      36'h0c00ca330, 36'h0c009aaa0};
   always #50 pclk = ~pclk;
   // sample clock with an odd phase against pclk
   // slow enough for one lane
   initial begin
      #137;
      forever #400 sample_clk = ~sample_clk;
   end
   aotpg_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .lane_strap_pin(lane_strap_pin), .pattern_strap_pin(pattern_strap_pin),
      .bank1_select_n(bank1_select_n), .bank2_select_n(bank2_select_n),
      .sample_clk(sample_clk), .adc_data(adc_data), .frame_clock_out_a(fca),
      .frame_clock_out_b(fcb), .data_clock_out_a(dca), .data_clock_out_b(dcb),
      .bank1_data_lanes(lanes1), .bank2_data_lanes(lanes2));
   aotpg_rx_model u_rx (.pclk(pclk), .presetn(presetn), .frame_clk(fca),
      .lanes(lanes1[1:0]), .word(rx_word), .valid(rx_valid));
   // second receiver on the last bank-2 channel, framed by the bank-2 frame clock
   aotpg_rx_model u_rx2 (.pclk(pclk), .presetn(presetn), .frame_clk(fcb),
      .lanes(lanes2[7:6]), .word(rx2_word), .valid(rx2_valid));
   // ==========================================
   // shared tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one apb transfer; held until pready is sampled high
   // an idle edge first, so psel is never driven twice in one step; the watchdog ends a hang
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic get_word(output logic [15:0] wd);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (rx_valid !== 1'b1 && n < 40);
      if (n >= 40) fail_count++;
      wd = rx_word;
      check({15'h0, rx2_valid, rx2_word}, {15'h0, 1'b1, rx_word});
   endtask
   task automatic do_reset(input logic lane, input logic pat, input logic sel);
      @(posedge pclk);
      presetn <= 1'b0;
      lane_strap_pin <= lane;
      pattern_strap_pin <= pat;
      bank1_select_n <= sel;
      bank2_select_n <= sel;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
   endtask
   // up to two words in flight may predate a change, so two are skipped
   task automatic alt_check(input logic [3:0] code, input logic [15:0] w1, w2);
      logic [15:0] a, b, c;
      apb(1'b1, `AOTPG_ADDR_CTRL, {28'h0, code});
      get_word(a);
      get_word(a);
      get_word(a);
      get_word(b);
      get_word(c);
      check({31'h0, (a === w1 && b === w2) || (a === w2 && b === w1)}, 32'h1);
      check({16'h0, c}, {16'h0, a});
   endtask
   task automatic prbs_check(input logic [31:0] ctrl, input logic [63:0] seq);
      int n;
      apb(1'b1, `AOTPG_ADDR_CTRL, 32'h3);
      apb(1'b1, `AOTPG_ADDR_CTRL, ctrl);
      n = 0;
      do begin
         get_word(w);
         n++;
      end while (w !== seq[63:48] && n < 4);
      check({16'h0, w}, {16'h0, seq[63:48]});
      for (int i = 2; i >= 0; i--) begin
         get_word(w);
         check({16'h0, w}, {16'h0, seq[i*16 +: 16]});
      end
   endtask
   task automatic complete_run;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ==========================================
   // tests
   initial begin
      do_reset(1'b1, 1'b1, 1'b1);
      apb(1'b0, `AOTPG_ADDR_STAT, 32'h0);
      check({30'h0, rdat[1:0]}, 32'h2);
      apb(1'b1, `AOTPG_ADDR_CTRL, 32'h2);
      get_word(w);
      get_word(w);
      check({16'h0, w}, 32'h8000);
      apb(1'b0, `AOTPG_ADDR_STAT, 32'h0);
      check({24'h0, rdat[7:0]}, 32'he);
      do_reset(1'b0, 1'b0, 1'b1);
      apb(1'b0, `AOTPG_ADDR_STAT, 32'h0);
      check({30'h0, rdat[1:0]}, 32'h1);
      $display("TEST straps done");
      do_reset(1'b1, 1'b0, 1'b0);
      apb(1'b0, `AOTPG_ADDR_FMT, 32'h0);
      check(rdat, 32'h1000);
      apb(1'b0, `AOTPG_ADDR_USER1, 32'h0);
      check(rdat, 32'h0);
      foreach (tab[i]) begin
         apb(1'b1, `AOTPG_ADDR_FMT, {16'h0, tab[i][35:20]});
         apb(1'b1, `AOTPG_ADDR_CTRL, {28'h0, tab[i][19:16]});
         get_word(w);
         get_word(w);
         get_word(w);
         check({16'h0, w}, {16'h0, tab[i][15:0]});
      end
      apb(1'b1, `AOTPG_ADDR_FMT, 32'h1100);
      apb(1'b0, `AOTPG_ADDR_FMT, 32'h0);
      check(rdat, 32'h0c00);
      $display("TEST fixed words done");
      apb(1'b1, `AOTPG_ADDR_FMT, 32'h1000);
      apb(1'b1, `AOTPG_ADDR_USER1, 32'h1234);
      apb(1'b1, `AOTPG_ADDR_USER2, 32'hbeef);
      alt_check(4'h4, 16'haaa8, 16'h5554);
      alt_check(4'h7, 16'hfffc, 16'h0000);
      alt_check(4'h8, 16'h1234, 16'hbeef);
      $display("TEST two-word patterns done");
      prbs_check(32'h26, 64'h7f80_77c4_f320_a538);
      prbs_check(32'h15, 64'h7ffc_7f80_8004_7000);
      $display("TEST pseudorandom done");
      bank2_select_n <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b1, `AOTPG_ADDR_CTRL, 32'h2);
      apb(1'b0, `AOTPG_ADDR_STAT, 32'h0);
      check({22'h0, rdat[11:2]}, {22'h0, 4'h5, 4'h2, 2'b10});
      $display("TEST bank gating done");
      apb(1'b0, 8'h14, 32'h0);
      check({31'h0, rerr}, 32'h1);
      check(rdat, 32'h0);
      apb(1'b0, 8'h02, 32'h0);
      check({31'h0, rerr}, 32'h1);
      $display("TEST bus errors done");
      complete_run();
   end
   // watchdog: the whole sequence needs well under a tenth of this span
   initial begin
      #3000000;
      fail_count++;
      complete_run();
   end
endmodule
